// ===== inc/lock_cfg.svh
/*
 * constants for the host access lock block: register offsets, lock bit
 * positions, reset values.
 * assumes inclusion by bare name from the gate, the top design file and the testbench.
 */
`ifndef LOCK_CFG_SVH
`define LOCK_CFG_SVH
`define OFS_LOCK_ONE 8'h05
`define ADDR_LOCK_ONE 8'h14
`define ADDR_BUS_CFG 8'h20
`define ADDR_IRQ_STATUS 8'h24
`define ADDR_IRQ_ENABLE 8'h28
`define ADDR_IRQ_CLEAR 8'h2c
`define ADDR_MOD_ENABLE 8'h30
`define ADDR_VIOL_INFO 8'h34
`define BIT_CONFIG_LOCK 7
`define BIT_KBD_LOCK 4
`define BIT_SER1_LOCK 3
`define BIT_SER2_LOCK 2
`define BIT_PAR_LOCK 1
`define BIT_FDC_LOCK 0
`define LOCK_WRITE_MASK 8'h9f
`define LOCK_RESET 8'h00
`define BUS_CFG_RESET 2'h0
`define MOD_ENABLE_RESET 8'h00
`define IRQ_VIOL_BIT 0
`define IRQ_LOCK_CHG_BIT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== inc/lock_pkg.sv
/*
 * types shared by the host access lock design files.
 * assumes nothing beyond the constants header.
 */
package lock_pkg;
    typedef enum logic [1:0]
    {
        VIOL_IGNORE = 2'b00,
        VIOL_ERROR = 2'b01,
        VIOL_ALL_ONES = 2'b10,
        VIOL_RESERVED = 2'b11
    } viol_mode_e;
    typedef enum logic [1:0]
    {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_e;
    typedef logic [7:0] lock_t;
endpackage

// ===== logic/lock_gate.sv
/*
 * per module access gate: decides whether an LPC access may pass, flags a
 * violation, and forces the module active while its lock bit is set.
 * assumes one lock bit and one enable pair per module, synchronous inputs.
 */
`timescale 1ns/1ps
`include "lock_cfg.svh"
module lock_gate
    import lock_pkg::*;
#(
    parameter int N = 8
)
(
    input wire logic [N-1:0] lock,
    input wire logic [N-1:0] act_bit,
    input wire logic global_en,
    input wire logic [N-1:0] lpc_sel,
    input wire logic [N-1:0] smb_sel,
    output logic [N-1:0] lpc_grant,
    output logic [N-1:0] smb_grant,
    output logic [N-1:0] viol_hit,
    output logic [N-1:0] active
);
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gate
            assign lpc_grant[g] = lpc_sel[g] & ~lock[g]; // R02
            assign viol_hit[g] = lpc_sel[g] & lock[g]; // R03
            assign smb_grant[g] = smb_sel[g]; // R12
            assign active[g] = lock[g] | (act_bit[g] & global_en); // R07
        end
    endgenerate
endmodule

// ===== logic/lock_irq.sv
/*
 * sticky event status with enable and write-one-to-clear; set wins over clear.
 * assumes single-cycle event pulses.
 */
`timescale 1ns/1ps
module lock_irq
#(
    parameter int N = 2
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [N-1:0] event_in,
    input wire logic [N-1:0] clear,
    input wire logic [N-1:0] enable,
    output logic [N-1:0] status,
    output logic irq
);
    logic [N-1:0] next_status;
    assign next_status = (status & ~clear) | event_in;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            status <= '0;
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            irq <= |(next_status & enable);
        end
    end
endmodule

// ===== logic/host_access_lock.sv
/*
 * host access lock register one with its LPC gating, violation flagging,
 * module forced activation and an AXI4-Lite register slave.
 * assumes LPC and serial-bus decode strobes are one-cycle, synchronous to CLK.
 */
// Register access over AXI4-Lite is this design's own decision.
// Operation
// [R01] lock register clears to 00h on reset, all modules unlocked.
// [R02] a zero lock bit leaves its module open to LPC accesses.
// [R03] bit 7 set blocks LPC access to configuration module.
// [R04] locked LPC access answers per violation response mode field.
// [R05] each locked LPC access sets the lock violation flag.
// [R06] bit 4 set blocks LPC access to keyboard/mouse controller.
// [R07] a set lock bit forces its module active over enables.
// [R08] bit 3 locks serial port one, overriding its fast-disable bit.
// [R09] bit 2 locks serial port two like serial port one.
// [R10] bit 1 locks the parallel port like serial port one.
// [R11] bit 0 locks the floppy controller like serial port one.
// [R12] serial management bus accesses pass regardless of locks.
`timescale 1ns/1ps
`include "lock_cfg.svh"
module host_access_lock
    import lock_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [7:0] LPC_SEL,
    input wire logic [7:0] SMB_SEL,
    input wire logic SER1_FAST_DISABLE,
    input wire logic SER2_FAST_DISABLE,
    output logic [7:0] LPC_GRANT,
    output logic [7:0] SMB_GRANT,
    output logic LPC_VIOL,
    output logic [1:0] LPC_VIOL_MODE,
    output logic [7:0] MOD_ACTIVE,
    output logic LOCK_VIOLATION_FLAG,
    output logic IRQ
);
    lock_t host_access_lock_one;
    logic [1:0] lock_violation_response_mode;
    lock_t mod_enable;
    logic global_module_enable;
    lock_t last_viol_sel;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic irq_line;

    // write channel
    wr_state_e wr_state;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = AWVALID & AWREADY;
    wire w_take = WVALID & WREADY;
    wire have_aw = aw_held | aw_take;
    wire have_w = w_held | w_take;
    wire [7:0] wr_addr = aw_held ? aw_addr : AWADDR;
    wire [31:0] wr_data = w_held ? w_data : WDATA;
    wire [3:0] wr_strb = w_held ? w_strb : WSTRB;
    wire wr_fire = (wr_state == WR_IDLE) & have_aw & have_w;
    wire wr_lock = wr_fire & (wr_addr == `ADDR_LOCK_ONE) & wr_strb[0];
    wire wr_cfg = wr_fire & (wr_addr == `ADDR_BUS_CFG) & wr_strb[0];
    wire wr_ien = wr_fire & (wr_addr == `ADDR_IRQ_ENABLE) & wr_strb[0];
    wire wr_iclr = wr_fire & (wr_addr == `ADDR_IRQ_CLEAR) & wr_strb[0];
    wire wr_men = wr_fire & (wr_addr == `ADDR_MOD_ENABLE) & wr_strb[0];
    wire wr_ok = (wr_addr == `ADDR_LOCK_ONE) | (wr_addr == `ADDR_BUS_CFG)
        | (wr_addr == `ADDR_IRQ_ENABLE) | (wr_addr == `ADDR_IRQ_CLEAR)
        | (wr_addr == `ADDR_MOD_ENABLE) | (wr_addr == `ADDR_IRQ_STATUS)
        | (wr_addr == `ADDR_VIOL_INFO);
    wire [1:0] iclr_bits = wr_iclr ? wr_data[1:0] : 2'h0;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            wr_state <= WR_IDLE;
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                wr_state <= WR_RESP;
                BVALID <= 1'b1;
                BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
                wr_state <= WR_IDLE;
            end
        end
    end
    assign AWREADY = (wr_state == WR_IDLE) & ~aw_held;
    assign WREADY = (wr_state == WR_IDLE) & ~w_held;

    // read channel
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (ARADDR)
            `ADDR_LOCK_ONE: rd_mux = {24'h0, host_access_lock_one};
            `ADDR_BUS_CFG: rd_mux = {30'h0, lock_violation_response_mode};
            `ADDR_IRQ_STATUS: rd_mux = {30'h0, irq_status};
            `ADDR_IRQ_ENABLE: rd_mux = {30'h0, irq_enable};
            `ADDR_IRQ_CLEAR: rd_mux = 32'h0;
            `ADDR_MOD_ENABLE: rd_mux = {24'h0, mod_enable};
            `ADDR_VIOL_INFO: rd_mux = {24'h0, last_viol_sel};
            default:
            begin
                rd_mux = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end
    assign ARREADY = ~RVALID;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            RVALID <= 1'b1;
            RDATA <= rd_mux;
            RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
        end
    end

    // lock, configuration and module enable registers
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            host_access_lock_one <= `LOCK_RESET; // R01
            lock_violation_response_mode <= `BUS_CFG_RESET;
            mod_enable <= `MOD_ENABLE_RESET;
            global_module_enable <= 1'b0;
            irq_enable <= 2'h0;
        end
        else
        begin
            if (wr_lock)
                host_access_lock_one <= wr_data[7:0] & `LOCK_WRITE_MASK;
            if (wr_cfg)
                lock_violation_response_mode <= wr_data[1:0];
            if (wr_men)
            begin
                mod_enable <= wr_data[7:0];
                global_module_enable <= wr_data[8];
            end
            if (wr_ien)
                irq_enable <= wr_data[1:0];
        end
    end

    // per-module activation bits, serial ports also gated by fast disable
    wire [7:0] act_bits;
    assign act_bits[`BIT_SER1_LOCK] = mod_enable[`BIT_SER1_LOCK] & ~SER1_FAST_DISABLE; // R08
    assign act_bits[`BIT_SER2_LOCK] = mod_enable[`BIT_SER2_LOCK] & ~SER2_FAST_DISABLE; // R09
    assign act_bits[7:4] = mod_enable[7:4];
    assign act_bits[1:0] = mod_enable[1:0];

    wire [7:0] grant_c;
    wire [7:0] smb_c;
    wire [7:0] viol_c;
    wire [7:0] active_c;
    lock_gate #(.N(8)) u_gate
    (
        .lock(host_access_lock_one),
        .act_bit(act_bits),
        .global_en(global_module_enable),
        .lpc_sel(LPC_SEL),
        .smb_sel(SMB_SEL),
        .lpc_grant(grant_c),
        .smb_grant(smb_c),
        .viol_hit(viol_c),
        .active(active_c)
    );
    wire viol_any = |viol_c; // R03 R06 R08 R09 R10 R11

    lock_irq #(.N(2)) u_irq
    (
        .CLK(CLK),
        .RST_N(RST_N),
        .event_in({wr_lock, viol_any}),
        .clear(iclr_bits),
        .enable(irq_enable),
        .status(irq_status),
        .irq(irq_line)
    );

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LPC_GRANT <= 8'h00;
            SMB_GRANT <= 8'h00;
            LPC_VIOL <= 1'b0;
            LPC_VIOL_MODE <= 2'h0;
            MOD_ACTIVE <= 8'h00;
            last_viol_sel <= 8'h00;
            IRQ <= 1'b0;
        end
        else
        begin
            LPC_GRANT <= grant_c; // R02
            SMB_GRANT <= smb_c; // R12
            LPC_VIOL <= viol_any; // R05
            LPC_VIOL_MODE <= lock_violation_response_mode; // R04
            MOD_ACTIVE <= active_c; // R07
            if (viol_any)
                last_viol_sel <= viol_c;
            IRQ <= irq_line;
        end
    end
    assign LOCK_VIOLATION_FLAG = irq_status[`IRQ_VIOL_BIT]; // R05

    chk_reset_clear: assert property (@(posedge CLK) $rose(RST_N) |-> host_access_lock_one == 8'h00) // R01
        else $error("lock register not clear after reset");
    chk_open_grant: assert property (@(posedge CLK) disable iff (!RST_N) // R02
        (LPC_SEL[0] && !host_access_lock_one[0]) |=> LPC_GRANT[0])
        else $error("unlocked access not granted");
    chk_config_block: assert property (@(posedge CLK) disable iff (!RST_N) // R03
        (LPC_SEL[7] && host_access_lock_one[7]) |=> !LPC_GRANT[7] && LPC_VIOL)
        else $error("config module not blocked");
    chk_viol_mode: assert property (@(posedge CLK) disable iff (!RST_N) // R04
        viol_any |=> LPC_VIOL && LPC_VIOL_MODE == $past(lock_violation_response_mode))
        else $error("violation mode not presented");
    chk_viol_flag: assert property (@(posedge CLK) disable iff (!RST_N) // R05
        viol_any |=> LOCK_VIOLATION_FLAG)
        else $error("violation flag not set");
    chk_kbd_block: assert property (@(posedge CLK) disable iff (!RST_N) // R06
        (LPC_SEL[4] && host_access_lock_one[4]) |=> !LPC_GRANT[4] && LPC_VIOL)
        else $error("keyboard module not blocked");
    chk_kbd_active: assert property (@(posedge CLK) disable iff (!RST_N) // R07
        host_access_lock_one[4] |=> MOD_ACTIVE[4])
        else $error("locked keyboard module not active");
    chk_force_active: assert property (@(posedge CLK) disable iff (!RST_N) // R08
        host_access_lock_one[3] |=> MOD_ACTIVE[3])
        else $error("locked serial port one not active");
    chk_ser_one_block: assert property (@(posedge CLK) disable iff (!RST_N) // R08
        (LPC_SEL[3] && host_access_lock_one[3]) |=> !LPC_GRANT[3] && LPC_VIOL)
        else $error("serial port one not blocked");
    chk_ser_two_lock: assert property (@(posedge CLK) disable iff (!RST_N) // R09
        host_access_lock_one[2] |=> MOD_ACTIVE[2] && !LPC_GRANT[2])
        else $error("locked serial port two not active or still granted");
    chk_par_block: assert property (@(posedge CLK) disable iff (!RST_N) // R10
        (LPC_SEL[1] && host_access_lock_one[1]) |=> !LPC_GRANT[1] && MOD_ACTIVE[1])
        else $error("parallel port not blocked");
    chk_floppy_block: assert property (@(posedge CLK) disable iff (!RST_N) // R11
        (LPC_SEL[0] && host_access_lock_one[0]) |=> !LPC_GRANT[0] && LPC_VIOL)
        else $error("floppy controller not blocked");
    chk_smb_pass: assert property (@(posedge CLK) disable iff (!RST_N) // R12
        SMB_SEL[2] |=> SMB_GRANT[2])
        else $error("serial bus access blocked");
    cov_violation: cover property (@(posedge CLK) disable iff (!RST_N) LPC_VIOL);
    cov_lock_write: cover property (@(posedge CLK) disable iff (!RST_N) wr_lock);
    cov_irq: cover property (@(posedge CLK) disable iff (!RST_N) IRQ);
    cov_fast_override: cover property (@(posedge CLK) disable iff (!RST_N)
        SER1_FAST_DISABLE && MOD_ACTIVE[3]);
endmodule

// ===== testbench/host_side_model.sv
/*
 * far side model: LPC host chipset and serial management bus controller,
 * each access a one-cycle module select strobe.
 * assumes the bench clock; callers give an idle gap of at least one cycle.
 */
`timescale 1ns/1ps
module host_side_model
(
    input wire logic clk,
    output logic [7:0] lpc_sel,
    output logic [7:0] smb_sel
);
    initial
    begin
        lpc_sel = 8'h00;
        smb_sel = 8'h00;
    end
    // strobes drop after one edge so the block never sees a stretched access
    task automatic access(input logic [7:0] lpc, input logic [7:0] smb, input int gap);
        lpc_sel <= lpc;
        smb_sel <= smb;
        @(posedge clk);
        lpc_sel <= 8'h00;
        smb_sel <= 8'h00;
        repeat (gap) @(posedge clk);
    endtask
endmodule

// ===== testbench/test_host_access_lock.sv
/*
 * self-checking bench for the host access lock block: AXI4-Lite register
 * traffic, host and serial bus strobes, interrupt and forced activation.
 * assumes the design's constants header and package.
 */
`timescale 1ns/1ps
`include "lock_cfg.svh"
module test_host_access_lock
    import lock_pkg::*;
;
    logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SER1_FAST_DISABLE;
    logic SER2_FAST_DISABLE, AWREADY, WREADY, BVALID, ARREADY, RVALID, LPC_VIOL;
    logic LOCK_VIOLATION_FLAG, IRQ, sel_seen;
    logic [7:0] AWADDR, ARADDR, LPC_SEL, SMB_SEL, LPC_GRANT, SMB_GRANT, MOD_ACTIVE;
    logic [31:0] WDATA, RDATA, v;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, LPC_VIOL_MODE;
    logic [33:0] exp_q[$];
    logic [1:0] exp_b[$];
    logic [16:0] exp_p[$];
    lock_t lock;
    int miscompares, checked, cycles;
    int bits[6] = '{7, 4, 3, 2, 1, 0};

    host_access_lock u_dut(.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
        .RRESP, .RVALID, .RREADY, .LPC_SEL, .SMB_SEL, .SER1_FAST_DISABLE, .SER2_FAST_DISABLE,
        .LPC_GRANT, .SMB_GRANT, .LPC_VIOL, .LPC_VIOL_MODE, .MOD_ACTIVE, .LOCK_VIOLATION_FLAG,
        .IRQ);
    host_side_model u_far(.clk(CLK), .lpc_sel(LPC_SEL), .smb_sel(SMB_SEL));

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // result watcher: answers are matched against the oldest note
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
        if (RVALID && RREADY) check(exp_q.pop_front(), {RRESP, RDATA});
        if (BVALID && BREADY) check({32'h0, exp_b.pop_front()}, {32'h0, BRESP});
        sel_seen <= (LPC_SEL | SMB_SEL) != 8'h00;
    end
    always @(negedge CLK)
        if (sel_seen) check({17'h0, exp_p.pop_front()}, {17'h0, LPC_VIOL, LPC_GRANT, SMB_GRANT});

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        exp_b.push_back(r);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!b)
        begin
            @(posedge CLK);
            aw = aw && !AWREADY;
            w = w && !WREADY;
            AWVALID <= aw;
            WVALID <= w;
            b = BVALID;
        end
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ar, got;
        ar = 1'b1;
        got = 1'b0;
        exp_q.push_back(e);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (!got)
        begin
            @(posedge CLK);
            ar = ar && !ARREADY;
            ARVALID <= ar;
            got = RVALID;
        end
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic wrlock(input logic [7:0] d);
        lock = d & 8'h9f;
        wr(`ADDR_LOCK_ONE, {24'h0, d}, `RESP_OKAY);
    endtask

    task automatic port(input logic [7:0] l, input logic [7:0] s, input int gap);
        exp_p.push_back({(l & lock) != 8'h00, l & ~lock, s});
        u_far.access(l, s, gap);
    endtask

    initial
    begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
        {SER1_FAST_DISABLE, SER2_FAST_DISABLE, sel_seen} = 3'h0;
        {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
        WSTRB = 4'hf;
        {miscompares, checked, cycles} = 96'h0;
        lock = 8'h00;
        void'($urandom(19));
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rd(`ADDR_LOCK_ONE, 34'h0);
        rd(`ADDR_BUS_CFG, 34'h0);
        port(8'hff, 8'h00, 1);
        for (int i = 0; i < 6; i++)
        begin
            wrlock(8'(1 << bits[i]));
            port(8'hff, 8'hff, 1);
            check({26'h0, lock}, {26'h0, MOD_ACTIVE});
        end
        repeat (20)
        begin
            v = $urandom;
            wrlock(v[7:0]);
            rd(`ADDR_LOCK_ONE, {26'h0, lock});
            port(v[15:8], v[23:16] | 8'h80, 1 + int'(v[25:24]));
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(`ADDR_BUS_CFG, 32'(m), `RESP_OKAY);
            rd(`ADDR_BUS_CFG, {2'h0, 32'(m)});
            check({32'h0, 2'(m)}, {32'h0, LPC_VIOL_MODE});
        end
        wrlock(8'h10);
        rd(`ADDR_IRQ_STATUS, 34'h3);
        wr(`ADDR_IRQ_CLEAR, 32'h3, `RESP_OKAY);
        wr(`ADDR_IRQ_ENABLE, 32'h0, `RESP_OKAY);
        port(8'h18, 8'h00, 2);
        check(34'h1, {33'h0, LOCK_VIOLATION_FLAG});
        check(34'h0, {33'h0, IRQ});
        rd(`ADDR_IRQ_STATUS, 34'h1);
        rd(`ADDR_VIOL_INFO, 34'h10);
        wr(`ADDR_IRQ_ENABLE, 32'h1, `RESP_OKAY);
        @(posedge CLK);
        check(34'h1, {33'h0, IRQ});
        wr(`ADDR_IRQ_CLEAR, 32'h1, `RESP_OKAY);
        @(posedge CLK);
        check(34'h0, {32'h0, IRQ, LOCK_VIOLATION_FLAG});
        rd(`ADDR_IRQ_CLEAR, 34'h0);
        // fast disables hold serial ports off unless their lock overrides
        SER1_FAST_DISABLE <= 1'b1;
        SER2_FAST_DISABLE <= 1'b1;
        wr(`ADDR_MOD_ENABLE, 32'h1ff, `RESP_OKAY);
        wrlock(8'h00);
        @(posedge CLK);
        check(34'hf3, {26'h0, MOD_ACTIVE});
        wrlock(8'h0c);
        @(posedge CLK);
        check(34'hff, {26'h0, MOD_ACTIVE});
        wr(`ADDR_MOD_ENABLE, 32'h0ff, `RESP_OKAY);
        @(posedge CLK);
        check(34'h0c, {26'h0, MOD_ACTIVE});
        rd(`ADDR_MOD_ENABLE, 34'hff);
        wr(8'h3c, 32'h1, `RESP_SLVERR);
        rd(8'h3c, {`RESP_SLVERR, 32'h0});
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        lock = 8'h00;
        @(posedge CLK);
        rd(`ADDR_LOCK_ONE, 34'h0);
        tally_and_finish();
    end
endmodule
